// ==== mts_cfg.svh ====
`ifndef MTS_CFG_SVH
`define MTS_CFG_SVH

// register byte offsets
`define MTS_OFS_CTRL      8'h00
`define MTS_OFS_SCAN_CFG  8'h04
`define MTS_OFS_STAGE     8'h08
`define MTS_OFS_MOVE      8'h0C
`define MTS_OFS_AGE_CFG   8'h10
`define MTS_OFS_STATUS    8'h14
`define MTS_OFS_HIT_CNT   8'h18
`define MTS_OFS_STICKY    8'h1C
`define MTS_OFS_RDBACK    8'h20

// table command codes
`define MTS_CMD_WRITE     3'h1
`define MTS_CMD_READ      3'h2
`define MTS_CMD_SCAN      3'h5

// control register fields
`define MTS_CTRL_TRIG     0
`define MTS_CTRL_CMD_LSB  1
`define MTS_CTRL_ROW_LSB  8
`define MTS_CTRL_COL_LSB  20

// scan configuration bits
`define MTS_CFG_IDENT     0
`define MTS_CFG_DEST      1
`define MTS_CFG_PORT      2
`define MTS_CFG_SKIPLOCK  3
`define MTS_CFG_EXPIRED   4
`define MTS_CFG_AGEVAL    5
`define MTS_CFG_LALLVAL   6
`define MTS_CFG_STOP      7
`define MTS_CFG_AGE_RW    8
`define MTS_CFG_LALL_RW   9
`define MTS_CFG_RELOCATE  10
`define MTS_CFG_DELETE    11
`define MTS_CFG_SWAGE     12
`define MTS_CFG_IVM_LSB   16

// staging register fields
`define MTS_STG_KIND_LSB  13
`define MTS_STG_DEST_LSB  16
`define MTS_STG_AGE_LSB   28
`define MTS_STG_LALL      30
`define MTS_STG_LOCK      31

// move register fields
`define MTS_MOVE_MASK_LSB 16

// aging register fields
`define MTS_AGE_PORT_LSB  16

// status register fields
`define MTS_STS_FOUND     0
`define MTS_STS_VALID     1

// sticky bits
`define MTS_STK_REMOVED   0
`define MTS_STK_ROWHIT    1

// reset values
`define MTS_RST_IVMASK    4'hF
`define MTS_RST_AGE_MAX   2'h3
`define MTS_RST_PORTMASK  16'hFFFF

`endif

// ==== mts_pkg.sv ====
package mts_pkg;

   typedef struct packed {
      logic        valid;
      logic        locked;
      logic [12:0] fid;
      logic [2:0]  kind;
      logic [11:0] dest;
      logic [1:0]  age;
      logic [1:0]  interval;
      logic        learn_all;
   } mts_entry_t;

   typedef struct packed {
      logic [3:0] interval_mask;
      logic       software_aging;
      logic       delete_hits;
      logic       relocate_hits;
      logic       learn_all_rewrite;
      logic       age_rewrite;
      logic       stop_on_hit;
      logic       learn_all_match;
      logic       age_value_match;
      logic       expired_only;
      logic       skip_pinned;
      logic       aging_port_restrict;
      logic       destination_match;
      logic       ident_match;
   } mts_scan_cfg_t;

   typedef enum logic {
      MTS_IDLE,
      MTS_SCAN
   } mts_state_t;

endpackage : mts_pkg

// ==== mts_scan_engine.sv ====
`timescale 1ns/10ps
// Summary of operation
// - trigger stays set until scan finishes
// - walk entries; stop or modify matches
// - find-next starts at software row/column
// - stop-on-hit selects halt or full walk
// - identifier filter compares staged identifier
// - destination filter with mask wildcards
// - aging port filter restricts destination ports
// - optionally exclude locked entries
// - aged-only matches counter at maximum
// - interval mask selects allowed intervals
// - age value and learn-all equality filters
// - rewrite aging counter of found entries
// - rewrite learn-all flag of found entries
// - move found destinations under mask
// - delete found entries, sticky removal flag
// - software aging: delete aged, increment others
// - report last match location and result
// - count matched entries during scan
// - sticky flag on row with match
`include "mts_cfg.svh"

module mts_scan_engine
   import mts_pkg::*;
#(
   parameter int ROW_W = 4,
   parameter int COL_W = 2
)
(
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata
);

   localparam int IW = ROW_W + COL_W;
   localparam int N  = 1 << IW;

   mts_entry_t         tbl_reg [N];
   mts_state_t         state_reg;
   logic               trig_reg;
   logic [2:0]         cmd_reg;
   logic [ROW_W-1:0]   row_reg;
   logic [COL_W-1:0]   col_reg;
   mts_scan_cfg_t      cfg_reg;
   mts_entry_t         stage_reg;
   logic [11:0]        new_dest_reg;
   logic [11:0]        dest_mask_reg;
   logic [1:0]         age_max_reg;
   logic [15:0]        port_mask_reg;
   logic [IW-1:0]      idx_reg;
   logic               found_reg;
   logic [IW-1:0]      pos_reg;
   logic [31:0]        hit_counter_reg;
   logic               removed_stk_reg;
   logic               rowhit_stk_reg;
   mts_entry_t         rdback_reg;

   mts_entry_t         cur;
   mts_entry_t         upd;
   logic               hit;
   logic               scanning;
   logic               last;
   logic               start;
   logic               finish;
   logic               wr_ctrl;

   assign scanning = (state_reg == MTS_SCAN);
   assign last     = (idx_reg == {IW{1'b1}});
   assign start    = (state_reg == MTS_IDLE) && trig_reg && (cmd_reg == `MTS_CMD_SCAN);
   assign finish   = scanning && (last || (hit && cfg_reg.stop_on_hit));
   // control is frozen during a scan so a stray write cannot restart it
   assign wr_ctrl  = reg_wr && (reg_addr == `MTS_OFS_CTRL) && !trig_reg;
   assign cur      = tbl_reg[idx_reg];

   // filter evaluation; each enabled filter may only veto the match
   always_comb
   begin
      hit = scanning && cur.valid;
      if (cfg_reg.ident_match && (cur.fid != stage_reg.fid))
      begin
         hit = 1'b0;
      end
      if (cfg_reg.destination_match && ((cur.kind != stage_reg.kind)
          || (((cur.dest ^ stage_reg.dest) & dest_mask_reg) != 12'h000)))
      begin
         hit = 1'b0;
      end
      if (cfg_reg.aging_port_restrict
          && !((cur.kind == 3'h0) && port_mask_reg[cur.dest[3:0]]))
      begin
         hit = 1'b0;
      end
      if (cfg_reg.skip_pinned && cur.locked)
      begin
         hit = 1'b0;
      end
      if (cfg_reg.expired_only && (cur.age != age_max_reg))
      begin
         hit = 1'b0;
      end
      if (!cfg_reg.interval_mask[cur.interval])
      begin
         hit = 1'b0;
      end
      if (cfg_reg.age_value_match && (cur.age != stage_reg.age))
      begin
         hit = 1'b0;
      end
      if (cfg_reg.learn_all_match && (cur.learn_all != stage_reg.learn_all))
      begin
         hit = 1'b0;
      end
   end

   // modified entry; deletion overrides every other rewrite
   always_comb
   begin
      upd = cur;
      if (cfg_reg.age_rewrite)
      begin
         upd.age = stage_reg.age;
      end
      if (cfg_reg.learn_all_rewrite)
      begin
         upd.learn_all = stage_reg.learn_all;
      end
      if (cfg_reg.relocate_hits)
      begin
         upd.dest = (cur.dest & ~dest_mask_reg) | (new_dest_reg & dest_mask_reg);
      end
      if (cfg_reg.software_aging)
      begin
         if (cur.age == age_max_reg)
         begin
            upd.valid = 1'b0;
         end
         else
         begin
            upd.age = 2'(cur.age + 2'h1);
         end
      end
      if (cfg_reg.delete_hits)
      begin
         upd.valid = 1'b0;
      end
   end

   // command trigger and scan sequencing
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         state_reg <= MTS_IDLE;
         trig_reg  <= 1'b0;
         cmd_reg   <= 3'h0;
         row_reg   <= '0;
         col_reg   <= '0;
         idx_reg   <= '0;
      end
      else
      begin
         case (state_reg)
            MTS_IDLE:
            begin
               if (wr_ctrl)
               begin
                  trig_reg <= reg_wdata[`MTS_CTRL_TRIG];
                  cmd_reg  <= reg_wdata[`MTS_CTRL_CMD_LSB +: 3];
                  row_reg  <= reg_wdata[`MTS_CTRL_ROW_LSB +: ROW_W];
                  col_reg  <= reg_wdata[`MTS_CTRL_COL_LSB +: COL_W];
               end
               else if (start)
               begin
                  state_reg <= MTS_SCAN;
                  // full walks cover the whole table from entry zero
                  idx_reg   <= cfg_reg.stop_on_hit ? {row_reg, col_reg} : '0;
               end
               else if (trig_reg)
               begin
                  trig_reg <= 1'b0;
               end
            end
            MTS_SCAN:
            begin
               if (finish)
               begin
                  state_reg <= MTS_IDLE;
                  trig_reg  <= 1'b0;
               end
               else
               begin
                  idx_reg <= IW'(idx_reg + 1'b1);
               end
            end
            default:
            begin
               state_reg <= MTS_IDLE;
               trig_reg  <= 1'b0;
            end
         endcase
      end
   end

   // entry storage, written by direct write and by scan actions
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < N; i++)
         begin
            tbl_reg[i] <= '0;
         end
      end
      else if (hit)
      begin
         tbl_reg[idx_reg] <= upd;
      end
      else if ((state_reg == MTS_IDLE) && trig_reg && !wr_ctrl
               && (cmd_reg == `MTS_CMD_WRITE))
      begin
         tbl_reg[{row_reg, col_reg}] <= stage_reg;
      end
   end

   // direct read capture
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         rdback_reg <= '0;
      end
      else if ((state_reg == MTS_IDLE) && trig_reg && !wr_ctrl
               && (cmd_reg == `MTS_CMD_READ))
      begin
         rdback_reg <= tbl_reg[{row_reg, col_reg}];
      end
   end

   // scan result and counter
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         found_reg       <= 1'b0;
         pos_reg         <= '0;
         hit_counter_reg <= 32'h0000_0000;
      end
      else if (start)
      begin
         found_reg       <= 1'b0;
         hit_counter_reg <= 32'h0000_0000;
      end
      else if (hit)
      begin
         found_reg       <= 1'b1;
         pos_reg         <= idx_reg;
         hit_counter_reg <= hit_counter_reg + 32'h0000_0001;
      end
   end

   // sticky events: hardware set wins over a write-one clear
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         removed_stk_reg <= 1'b0;
         rowhit_stk_reg  <= 1'b0;
      end
      else
      begin
         if (hit && !upd.valid)
         begin
            removed_stk_reg <= 1'b1;
         end
         else if (reg_wr && (reg_addr == `MTS_OFS_STICKY) && reg_wdata[`MTS_STK_REMOVED])
         begin
            removed_stk_reg <= 1'b0;
         end
         if (hit)
         begin
            rowhit_stk_reg <= 1'b1;
         end
         else if (reg_wr && (reg_addr == `MTS_OFS_STICKY) && reg_wdata[`MTS_STK_ROWHIT])
         begin
            rowhit_stk_reg <= 1'b0;
         end
      end
   end

   // configuration registers; software keeps them still while busy
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         cfg_reg               <= '0;
         cfg_reg.interval_mask <= `MTS_RST_IVMASK;
         stage_reg             <= '0;
         new_dest_reg          <= 12'h000;
         dest_mask_reg         <= 12'h000;
         age_max_reg           <= `MTS_RST_AGE_MAX;
         port_mask_reg         <= `MTS_RST_PORTMASK;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            `MTS_OFS_SCAN_CFG:
            begin
               cfg_reg.ident_match         <= reg_wdata[`MTS_CFG_IDENT];
               cfg_reg.destination_match   <= reg_wdata[`MTS_CFG_DEST];
               cfg_reg.aging_port_restrict <= reg_wdata[`MTS_CFG_PORT];
               cfg_reg.skip_pinned         <= reg_wdata[`MTS_CFG_SKIPLOCK];
               cfg_reg.expired_only        <= reg_wdata[`MTS_CFG_EXPIRED];
               cfg_reg.age_value_match     <= reg_wdata[`MTS_CFG_AGEVAL];
               cfg_reg.learn_all_match     <= reg_wdata[`MTS_CFG_LALLVAL];
               cfg_reg.stop_on_hit         <= reg_wdata[`MTS_CFG_STOP];
               cfg_reg.age_rewrite         <= reg_wdata[`MTS_CFG_AGE_RW];
               cfg_reg.learn_all_rewrite   <= reg_wdata[`MTS_CFG_LALL_RW];
               cfg_reg.relocate_hits       <= reg_wdata[`MTS_CFG_RELOCATE];
               cfg_reg.delete_hits         <= reg_wdata[`MTS_CFG_DELETE];
               cfg_reg.software_aging      <= reg_wdata[`MTS_CFG_SWAGE];
               cfg_reg.interval_mask       <= reg_wdata[`MTS_CFG_IVM_LSB +: 4];
            end
            `MTS_OFS_STAGE:
            begin
               stage_reg.valid     <= 1'b1;
               stage_reg.fid       <= reg_wdata[12:0];
               stage_reg.kind      <= reg_wdata[`MTS_STG_KIND_LSB +: 3];
               stage_reg.dest      <= reg_wdata[`MTS_STG_DEST_LSB +: 12];
               stage_reg.age       <= reg_wdata[`MTS_STG_AGE_LSB +: 2];
               stage_reg.learn_all <= reg_wdata[`MTS_STG_LALL];
               stage_reg.locked    <= reg_wdata[`MTS_STG_LOCK];
            end
            `MTS_OFS_MOVE:
            begin
               new_dest_reg  <= reg_wdata[11:0];
               dest_mask_reg <= reg_wdata[`MTS_MOVE_MASK_LSB +: 12];
            end
            `MTS_OFS_AGE_CFG:
            begin
               age_max_reg   <= reg_wdata[1:0];
               port_mask_reg <= reg_wdata[`MTS_AGE_PORT_LSB +: 16];
            end
            default:
            begin
            end
         endcase
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || !reg_rd)
      begin
         reg_rdata <= 32'h0000_0000;
      end
      else
      begin
         reg_rdata <= 32'h0000_0000;
         case (reg_addr)
            `MTS_OFS_CTRL:
            begin
               reg_rdata[`MTS_CTRL_TRIG]              <= trig_reg;
               reg_rdata[`MTS_CTRL_CMD_LSB +: 3]      <= cmd_reg;
               reg_rdata[`MTS_CTRL_ROW_LSB +: ROW_W]  <= row_reg;
               reg_rdata[`MTS_CTRL_COL_LSB +: COL_W]  <= col_reg;
            end
            `MTS_OFS_SCAN_CFG:
            begin
               reg_rdata[12:0] <= {cfg_reg.software_aging, cfg_reg.delete_hits,
                                   cfg_reg.relocate_hits, cfg_reg.learn_all_rewrite,
                                   cfg_reg.age_rewrite, cfg_reg.stop_on_hit,
                                   cfg_reg.learn_all_match, cfg_reg.age_value_match,
                                   cfg_reg.expired_only, cfg_reg.skip_pinned,
                                   cfg_reg.aging_port_restrict, cfg_reg.destination_match,
                                   cfg_reg.ident_match};
               reg_rdata[`MTS_CFG_IVM_LSB +: 4] <= cfg_reg.interval_mask;
            end
            `MTS_OFS_STAGE:
            begin
               reg_rdata <= {stage_reg.locked, stage_reg.learn_all, stage_reg.age,
                             stage_reg.dest, stage_reg.kind, stage_reg.fid};
            end
            `MTS_OFS_MOVE:
            begin
               reg_rdata[11:0]                     <= new_dest_reg;
               reg_rdata[`MTS_MOVE_MASK_LSB +: 12] <= dest_mask_reg;
            end
            `MTS_OFS_AGE_CFG:
            begin
               reg_rdata[1:0]                      <= age_max_reg;
               reg_rdata[`MTS_AGE_PORT_LSB +: 16]  <= port_mask_reg;
            end
            `MTS_OFS_STATUS:
            begin
               reg_rdata[`MTS_STS_FOUND]             <= found_reg;
               reg_rdata[`MTS_STS_VALID]             <= rdback_reg.valid;
               reg_rdata[`MTS_CTRL_ROW_LSB +: ROW_W] <= pos_reg[IW-1:COL_W];
               reg_rdata[`MTS_CTRL_COL_LSB +: COL_W] <= pos_reg[COL_W-1:0];
            end
            `MTS_OFS_HIT_CNT:
            begin
               reg_rdata <= hit_counter_reg;
            end
            `MTS_OFS_STICKY:
            begin
               reg_rdata[`MTS_STK_REMOVED] <= removed_stk_reg;
               reg_rdata[`MTS_STK_ROWHIT]  <= rowhit_stk_reg;
            end
            `MTS_OFS_RDBACK:
            begin
               reg_rdata <= {rdback_reg.locked, rdback_reg.learn_all, rdback_reg.age,
                             rdback_reg.dest, rdback_reg.kind, rdback_reg.fid};
            end
            default:
            begin
               reg_rdata <= 32'h0000_0000;
            end
         endcase
      end
   end

endmodule : mts_scan_engine

// ==== mts_scan_engine_properties.sv ====
`timescale 1ns/10ps
module mts_scan_engine_chk
   import mts_pkg::*;
#(
   parameter int ROW_W = 4,
   parameter int COL_W = 2
)
(
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata
);
   localparam int N = 1 << (ROW_W + COL_W);
   logic [15:0] since_reg;
   logic        scan_reg;
   logic        stop_reg;
   logic        stop_run_reg;
   wire         trig_wr = reg_wr && reg_addr == 8'h00 && reg_wdata[0];
   wire         rd_ctrl = reg_rd && reg_addr == 8'h00;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   // cycles since the last command launch, saturating
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         since_reg <= 16'hFFFF;
      else if (trig_wr)
         since_reg <= 16'h0;
      else if (since_reg != 16'hFFFF)
         since_reg <= since_reg + 16'h1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         stop_reg <= 1'b0;
      else if (reg_wr && reg_addr == 8'h04)
         stop_reg <= reg_wdata[7];
   end

   // stop mode latched at launch, later config writes must not disturb it
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         scan_reg     <= 1'b0;
         stop_run_reg <= 1'b0;
      end
      else if (trig_wr)
      begin
         scan_reg     <= reg_wdata[3:1] == 3'h5;
         stop_run_reg <= stop_reg;
      end
   end

   a_rdata_idle:
      assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data not idle");
   a_unmapped_zero:
      assert property (reg_rd && reg_addr[7:2] > 6'h08 |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_scan_busy:
      assert property (rd_ctrl && scan_reg && !stop_run_reg && since_reg <= N - 6 |=> reg_rdata[0])
      else $error("full walk ended early");
   a_scan_done:
      assert property (rd_ctrl && since_reg >= N + 6 |=> !reg_rdata[0])
      else $error("trigger never cleared");
   a_hit_range:
      assert property (reg_rd && reg_addr == 8'h18 |=> reg_rdata <= N)
      else $error("hit count above table size");
   a_find_single:
      assert property (reg_rd && reg_addr == 8'h18 && scan_reg && stop_run_reg |=> reg_rdata <= 1)
      else $error("find-next counted more than one");
   a_sticky_clear:
      assert property (reg_wr && reg_addr == 8'h1C && reg_wdata[1:0] == 2'h3 && !scan_reg
                       ##2 reg_rd && reg_addr == 8'h1C |=> reg_rdata[1:0] == 2'h0)
      else $error("sticky bits not cleared");
   a_cfg_readback:
      assert property (reg_wr && reg_addr == 8'h04 ##2 reg_rd && reg_addr == 8'h04
                       |=> (reg_rdata & 32'h000F1FFF) == ($past(reg_wdata, 3) & 32'h000F1FFF))
      else $error("scan config readback wrong");
endmodule : mts_scan_engine_chk

bind mts_scan_engine mts_scan_engine_chk #(.ROW_W(ROW_W), .COL_W(COL_W)) u_chk (
   .sys_clk   (sys_clk),
   .sys_rst   (sys_rst),
   .reg_addr  (reg_addr),
   .reg_wdata (reg_wdata),
   .reg_wr    (reg_wr),
   .reg_rd    (reg_rd),
   .reg_rdata (reg_rdata)
);

// ==== testbench.sv ====
`timescale 1ns/10ps
module testbench
   import mts_pkg::*;
;
   logic        sys_clk;
   logic        sys_rst;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic [31:0] ent [64];
   logic        vld [64];
   logic [31:0] cfg, stg, mv, ag, d, w;
   logic        rm, rh;
   int          fail_count, cmp_count, seed, s, i, hits, last, st_i;

   mts_scan_engine #(.ROW_W(4), .COL_W(2)) dut (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .reg_addr  (reg_addr),
      .reg_wdata (reg_wdata),
      .reg_wr    (reg_wr),
      .reg_rd    (reg_rd),
      .reg_rdata (reg_rdata)
   );

   initial sys_clk = 1'b0;
   always #2 sys_clk = ~sys_clk;

   task automatic conclude();
      $display("mismatches %0d compares %0d", fail_count, cmp_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1;
      v = reg_rdata;
   endtask : rd

   task automatic cmd(input logic [2:0] c, input int x);
      logic [31:0] v;
      int          k;
      v = 32'h1 | 32'(c) << 1 | 32'(x >> 2) << 8 | 32'(x & 3) << 20;
      wr(8'h00, v);
      // second launch while busy must be ignored
      if (c == 3'h5)
         wr(8'h00, v);
      // configuration stays untouched until the trigger clears
      for (k = 0; k < 300 && v[0]; k++)
         rd(8'h00, v);
      if (v[0])
      begin
         chk(32'h1, 32'h0);
         conclude();
      end
   endtask : cmd

   // reference walk; interval of stored entries is not visible, so mask is all or none
   task automatic model();
      logic [31:0] e;
      logic        m;
      hits = 0;
      last = 0;
      rm   = 1'b0;
      rh   = 1'b0;
      for (int j = (cfg[7] ? st_i : 0); j < 64; j++)
      begin
         e = ent[j];
         m = vld[j] && cfg[19:16] == 4'hF;
         if (cfg[0] && e[12:0] != stg[12:0])
            m = 1'b0;
         if (cfg[1] && (e[15:13] != stg[15:13] || ((e[27:16] ^ stg[27:16]) & mv[27:16]) != 0))
            m = 1'b0;
         if (cfg[2] && (e[15:13] != 3'h0 || !ag[16 + e[19:16]]))
            m = 1'b0;
         if (cfg[3] && e[31])
            m = 1'b0;
         if (cfg[4] && e[29:28] != ag[1:0])
            m = 1'b0;
         if (cfg[5] && e[29:28] != stg[29:28])
            m = 1'b0;
         if (cfg[6] && e[30] != stg[30])
            m = 1'b0;
         if (m)
         begin
            hits++;
            last = j;
            rh   = 1'b1;
            if (cfg[11] || (cfg[12] && e[29:28] == ag[1:0]))
            begin
               vld[j] = 1'b0;
               rm     = 1'b1;
            end
            else
            begin
               if (cfg[8])
                  e[29:28] = stg[29:28];
               if (cfg[9])
                  e[30] = stg[30];
               if (cfg[10])
                  e[27:16] = (e[27:16] & ~mv[27:16]) | (mv[11:0] & mv[27:16]);
               if (cfg[12])
                  e[29:28] = e[29:28] + 2'h1;
               ent[j] = e;
            end
            if (cfg[7])
               break;
         end
      end
   endtask : model

   initial
   begin
      sys_rst   = 1'b1;
      reg_addr  = 8'h00;
      reg_wdata = 32'h0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      seed      = 1432;
      for (i = 0; i < 64; i++)
         vld[i] = 1'b0;
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(8'h04, d);
      chk(d, 32'h000F0000);
      rd(8'h10, d);
      chk(d, 32'hFFFF0003);
      rd(8'h24, d);
      chk(d, 32'h0);
      // an unused command code must only clear the trigger
      cmd(3'h3, 0);
      for (s = 0; s < 12; s++)
      begin
         for (i = 0; i < 64; i++)
            if ($random(seed) & 1)
            begin
               w = $random(seed) & 32'hF00F2003;
               wr(8'h08, w);
               cmd(3'h1, i);
               ent[i] = w;
               vld[i] = 1'b1;
            end
         // sparse filters so that combined runs still hit
         cfg = $random(seed) & $random(seed) & 32'h7F | $random(seed) & 32'h1F00;
         if (s > 0)
            cfg[19:16] = 4'hF;
         // increment overrides the age rewrite in the engine
         if (cfg[12])
            cfg[8] = 1'b0;
         cfg[7] = (s % 3 == 1);
         stg    = $random(seed) & 32'hF00F2003;
         mv     = $random(seed) & 32'h0FFF0FFF;
         ag     = $random(seed) & 32'hFFFF0003;
         if (cfg[12])
            ag[1:0] = 2'h3;
         st_i = $random(seed) & 63;
         wr(8'h04, cfg);
         rd(8'h04, d);
         chk(d & 32'h000F1FFF, cfg);
         wr(8'h08, stg);
         wr(8'h0C, mv);
         wr(8'h10, ag);
         wr(8'h1C, 32'h3);
         rd(8'h1C, d);
         chk(d & 32'h3, 32'h0);
         model();
         cmd(3'h5, st_i);
         rd(8'h18, d);
         chk(d, 32'(hits));
         rd(8'h14, d);
         chk(d & 32'h1, 32'(hits > 0));
         if (hits > 0)
            chk(d & 32'h00300F00, 32'(last >> 2) << 8 | 32'(last & 3) << 20);
         rd(8'h1C, d);
         chk(d & 32'h3, {30'h0, rh, rm});
         // resume a find-next walk just past the previous hit
         if (cfg[7] && hits > 0 && last < 63)
         begin
            st_i = last + 1;
            model();
            cmd(3'h5, st_i);
            rd(8'h18, d);
            chk(d, 32'(hits));
            rd(8'h14, d);
            chk(d & 32'h1, 32'(hits > 0));
         end
         repeat (70) @(posedge sys_clk);
         rd(8'h00, d);
         chk(d & 32'h1, 32'h0);
         for (i = 0; i < 64; i++)
         begin
            cmd(3'h2, i);
            rd(8'h14, d);
            chk(32'(d[1]), 32'(vld[i]));
            rd(8'h20, d);
            if (vld[i])
               chk(d, ent[i]);
         end
      end
      conclude();
   end
endmodule : testbench
